//--- design/fcrc_unit.sv
// sixteen bit crc unit with byte input, indirect result and flash pass
//
// Contract
// - computes crc with a sixteen-bit polynomial into a sixteen-bit result
// - each input byte port write outside a pass is absorbed as the next byte
// - result lives in an internal register, updated after every byte
// - pointer selects result byte; data port reads or writes that byte
// - bit-reverse register returns written byte with mirrored bit order
// - result starts from selectable initial value, all zeros or all ones
// - each input byte is xored into the result's top eight bits
// - per step: shift left, xor polynomial when top bit was one
// - eight shift steps per byte before the next byte is taken
// - control write with auto enable set launches a flash pass
// - completion flag reads zero while a pass runs, else one
// - processor is stalled throughout a pass, so firmware reads one
// - five-bit start block field in the auto control low bits
// - first fetched address equals start block times 256
// - bit five of auto control reads zero, writes ignored
// - sector count register sets how many sectors a pass covers
`include "fcrc_cfg.svh"
`default_nettype none
module fcrc_unit (
   input  wire logic        ref_clk,        // system clock, 100 MHz
   input  wire logic        rst_n,          // async reset, active low
   input  wire logic [7:0]  sfr_addr,       // register address
   input  wire logic        sfr_wr,         // write strobe, one cycle
   input  wire logic        sfr_rd,         // read strobe, one cycle
   input  wire logic [7:0]  sfr_wdata,      // write data
   output logic [7:0]       sfr_rdata,      // read data, cycle after strobe
   output logic             cpu_stall,      // hold the processor
   output logic             flash_rd_req,   // flash read request pulse
   output logic [12:0]      flash_addr,     // flash byte address
   input  wire logic        flash_rd_valid, // flash data valid pulse
   input  wire logic [7:0]  flash_rd_data   // flash read data
);
   import fcrc_pkg::*;

   localparam logic [15:0] POLY = `FCRC_POLY;

   // ==================================================================
   // register decode
   logic        wr_ctrl;
   logic        wr_in;
   logic        wr_data;
   logic        wr_count;
   logic        wr_flip;
   logic        wr_auto;
   logic        rd_auto;

   assign wr_ctrl  = sfr_wr && (sfr_addr == `FCRC_ADDR_CTRL);
   assign wr_in    = sfr_wr && (sfr_addr == `FCRC_ADDR_IN);
   assign wr_data  = sfr_wr && (sfr_addr == `FCRC_ADDR_DATA);
   assign wr_count = sfr_wr && (sfr_addr == `FCRC_ADDR_COUNT);
   assign wr_flip  = sfr_wr && (sfr_addr == `FCRC_ADDR_FLIP);
   assign wr_auto  = sfr_wr && (sfr_addr == `FCRC_ADDR_AUTO);
   assign rd_auto  = sfr_rd && (sfr_addr == `FCRC_ADDR_AUTO);

   // ==================================================================
   // state
   logic [15:0] crc;
   logic [3:0]  bit_cnt;
   logic        result_ptr;
   logic        init_sel;
   logic        auto_en;
   logic [4:0]  start_blk;
   logic [7:0]  sector_count;
   logic [7:0]  flip;
   logic [15:0] remaining;
   fcrc_fetch_t fstate;
   fcrc_fetch_t next_fstate;

   logic        fifo_in_valid;
   logic        fifo_in_ready;
   logic [7:0]  fifo_in_data;
   logic        fifo_out_valid;
   logic        fifo_out_ready;
   logic [7:0]  fifo_out_data;
   logic        fifo_afull;
   logic        pass_busy;
   logic        launch;
   logic        sw_push;
   logic        fetch_push;
   logic        eng_pop;
   logic        init_now;
   logic [15:0] init_val;
   logic [15:0] loaded;
   logic [15:0] stepped;

   assign pass_busy = (fstate != FC_IDLE);
   assign launch    = wr_ctrl && auto_en && !pass_busy;
   assign init_now  = wr_ctrl && sfr_wdata[`FCRC_CTRL_INIT];
   assign init_val  = sfr_wdata[`FCRC_CTRL_INITSEL] ? `FCRC_INIT_ONES
                                                    : `FCRC_INIT_ZEROS;
   // software input is refused during a pass; the core is stalled then
   assign sw_push    = wr_in && !pass_busy;
   assign fetch_push = (fstate == FC_WAIT) && flash_rd_valid && !flash_rd_req;
   assign fifo_in_valid = sw_push || fetch_push;
   assign fifo_in_data  = fetch_push ? flash_rd_data : sfr_wdata;
   assign fifo_out_ready = (bit_cnt == 4'h0);
   assign eng_pop  = fifo_out_valid && fifo_out_ready;
   assign loaded   = crc ^ {fifo_out_data, 8'h00};
   assign stepped  = fcrc_step(crc, POLY);

   // ==================================================================
   // input buffer shared by software bytes and flash bytes
   fcrc_fifo #(
      .WIDTH (`FCRC_FIFO_WIDTH),
      .DEPTH (`FCRC_FIFO_DEPTH)
   ) u_fifo (
      .clk         (ref_clk),
      .rst_n       (rst_n),
      .in_valid    (fifo_in_valid),
      .in_ready    (fifo_in_ready),
      .in_data     (fifo_in_data),
      .out_valid   (fifo_out_valid),
      .out_ready   (fifo_out_ready),
      .out_data    (fifo_out_data),
      .almost_full (fifo_afull)
   );

   // ==================================================================
   // crc engine: init and software write win over the engine
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         crc <= `FCRC_INIT_ZEROS;
      end else if (init_now) begin
         crc <= init_val;
      end else if (wr_data) begin
         if (result_ptr) begin
            crc[15:8] <= sfr_wdata;
         end else begin
            crc[7:0] <= sfr_wdata;
         end
      end else if (eng_pop) begin
         crc <= loaded;
      end else if (bit_cnt != 4'h0) begin
         crc <= stepped;
      end
   end

   // bit step counter, eight steps per byte
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt <= 4'h0;
      end else if (eng_pop) begin
         bit_cnt <= `FCRC_BITS_PER_BYTE;
      end else if (bit_cnt != 4'h0) begin
         bit_cnt <= bit_cnt - 4'h1;
      end
   end

   // ==================================================================
   // software registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         result_ptr <= 1'(`FCRC_CTRL_RST >> `FCRC_CTRL_PTR);
         init_sel   <= 1'b0;
      end else if (wr_ctrl) begin
         result_ptr <= sfr_wdata[`FCRC_CTRL_PTR];
         init_sel   <= sfr_wdata[`FCRC_CTRL_INITSEL];
      end
   end

   // auto control; done and bit five are not stored
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         auto_en   <= 1'(`FCRC_AUTO_RST >> `FCRC_AUTO_EN);
         start_blk <= 5'h00;
      end else if (wr_auto) begin
         auto_en   <= sfr_wdata[`FCRC_AUTO_EN];
         start_blk <= sfr_wdata[`FCRC_AUTO_ST_MSB:0];
      end
   end

   // sector count of an automatic pass
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sector_count <= `FCRC_COUNT_RST;
      end else if (wr_count) begin
         sector_count <= sfr_wdata;
      end
   end

   // bit reverse register stores the mirrored byte
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flip <= 8'h00;
      end else if (wr_flip) begin
         flip <= fcrc_rev8(sfr_wdata);
      end
   end

   // read data is registered and holds until the next read
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         case (sfr_addr)
            `FCRC_ADDR_CTRL:  sfr_rdata <= {5'h00, init_sel, 1'b0,
                                            result_ptr};
            `FCRC_ADDR_DATA:  sfr_rdata <= result_ptr ? crc[15:8]
                                                      : crc[7:0];
            `FCRC_ADDR_COUNT: sfr_rdata <= sector_count;
            `FCRC_ADDR_FLIP:  sfr_rdata <= flip;
            `FCRC_ADDR_AUTO:  sfr_rdata <= {auto_en, !pass_busy, 1'b0,
                                            start_blk};
            default:          sfr_rdata <= 8'h00;
         endcase
      end
   end

   // ==================================================================
   // flash pass sequencer; one read is outstanding at a time
   always_comb begin
      next_fstate = fstate;
      case (fstate)
         FC_IDLE: begin
            if (launch) begin
               next_fstate = (sector_count == 8'h00) ? FC_DRAIN : FC_ISSUE;
            end
         end
         FC_ISSUE: begin
            if (fifo_in_ready) begin
               next_fstate = FC_WAIT;
            end
         end
         FC_WAIT: begin
            if (fetch_push) begin
               next_fstate = (remaining == 16'h0001) ? FC_DRAIN : FC_ISSUE;
            end
         end
         FC_DRAIN: begin
            if (!fifo_out_valid && bit_cnt == 4'h0) begin
               next_fstate = FC_IDLE;
            end
         end
         default: next_fstate = FC_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fstate <= FC_IDLE;
      end else begin
         fstate <= next_fstate;
      end
   end

   // fetch address and bytes left; addresses wrap at the flash top
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flash_addr <= 13'h0000;
         remaining  <= 16'h0000;
      end else if (launch) begin
         flash_addr <= {start_blk, 8'h00};
         remaining  <= {sector_count, 8'h00};
      end else if (fetch_push) begin
         flash_addr <= flash_addr + 13'h0001;
         remaining  <= remaining - 16'h0001;
      end
   end

   // request pulse in the first wait cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flash_rd_req <= 1'b0;
      end else begin
         flash_rd_req <= (fstate == FC_ISSUE) && fifo_in_ready;
      end
   end

   // stall covers the pass and a nearly full buffer
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_stall <= 1'b0;
      end else begin
         cpu_stall <= (next_fstate != FC_IDLE) || fifo_afull;
      end
   end

   // ==================================================================
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_step_count: assert property (
      eng_pop && !init_now && !wr_data |=> (bit_cnt == 4'h8) ##7
      (bit_cnt == 4'h1) ##1 (bit_cnt == 4'h0))
      else $error("byte did not take eight steps");

   a_byte_xor: assert property (
      eng_pop && !init_now && !wr_data |=> crc == $past(loaded))
      else $error("input byte not xored into top bits");

   a_shift_step: assert property (
      bit_cnt != 4'h0 && !eng_pop && !init_now && !wr_data
      |=> crc == $past(stepped))
      else $error("shift step wrong");

   a_init_value: assert property (
      init_now |=> crc == ($past(sfr_wdata[`FCRC_CTRL_INITSEL]) ?
                           `FCRC_INIT_ONES : `FCRC_INIT_ZEROS))
      else $error("initial value wrong");

   a_done_read: assert property (
      rd_auto |=> sfr_rdata[`FCRC_AUTO_DONE] == !$past(pass_busy))
      else $error("done flag mismatch");

   a_rsvd_zero: assert property (
      rd_auto |=> sfr_rdata[`FCRC_AUTO_RSVD] == 1'b0)
      else $error("reserved bit not zero");

   a_launch_pass: assert property (
      launch |=> pass_busy && cpu_stall)
      else $error("pass not launched");

   a_stall_pass: assert property (
      pass_busy |-> cpu_stall)
      else $error("processor not stalled during pass");

   a_start_addr: assert property (
      launch |=> flash_addr == {$past(start_blk), 8'h00})
      else $error("start address wrong");

   a_flip_byte: assert property (
      wr_flip |=> flip == fcrc_rev8($past(sfr_wdata)))
      else $error("bit reverse wrong");

   a_fetch_ascend: assert property (
      fetch_push && !launch |=> flash_addr == $past(flash_addr) + 13'h0001)
      else $error("fetch address not ascending");
endmodule
`default_nettype wire

//--- design/fcrc_cfg.svh
// register map, field positions, reset values and counts of the crc unit
`ifndef FCRC_CFG_SVH
`define FCRC_CFG_SVH

// ==================================================================
// register addresses on the special function register bus
`define FCRC_ADDR_CTRL     8'h84
`define FCRC_ADDR_IN       8'h85
`define FCRC_ADDR_DATA     8'h86
`define FCRC_ADDR_COUNT    8'h9a
`define FCRC_ADDR_FLIP     8'h9c
`define FCRC_ADDR_AUTO     8'h9e

// ==================================================================
// checksum control register fields
`define FCRC_CTRL_PTR      0
`define FCRC_CTRL_INITSEL  2
`define FCRC_CTRL_INIT     3

// ==================================================================
// auto control register fields
`define FCRC_AUTO_EN       7
`define FCRC_AUTO_DONE     6
`define FCRC_AUTO_RSVD     5
`define FCRC_AUTO_ST_MSB   4

// ==================================================================
// reset values and constants
`define FCRC_AUTO_RST      8'h40
`define FCRC_CTRL_RST      8'h00
`define FCRC_COUNT_RST     8'h00
`define FCRC_INIT_ZEROS    16'h0000
`define FCRC_INIT_ONES     16'hffff
`define FCRC_POLY          16'h1021
`define FCRC_BITS_PER_BYTE 4'h8
`define FCRC_FIFO_DEPTH    16
`define FCRC_FIFO_WIDTH    8

`endif

//--- design/fcrc_pkg.sv
// types and shared functions of the crc unit
`default_nettype none
package fcrc_pkg;
   // gray coded along idle, issue, wait, drain
   typedef enum logic [1:0] {
      FC_IDLE  = 2'b00,
      FC_ISSUE = 2'b01,
      FC_WAIT  = 2'b11,
      FC_DRAIN = 2'b10
   } fcrc_fetch_t;

   // one conditional shift and xor step
   function automatic logic [15:0] fcrc_step(input logic [15:0] crc,
                                             input logic [15:0] poly);
      fcrc_step = crc[15] ? ({crc[14:0], 1'b0} ^ poly) : {crc[14:0], 1'b0};
   endfunction

   // mirror the bit order of a byte
   function automatic logic [7:0] fcrc_rev8(input logic [7:0] b);
      integer i;
      fcrc_rev8 = 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
         fcrc_rev8[i] = b[7 - i];
      end
   endfunction
endpackage
`default_nettype wire

//--- design/fcrc_fifo.sv
// byte fifo between the input sources and the crc engine
`default_nettype none
module fcrc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,         // system clock
   input  wire logic             rst_n,       // async reset, active low
   input  wire logic             in_valid,    // push request
   output logic                  in_ready,    // room for one word
   input  wire logic [WIDTH-1:0] in_data,     // pushed word
   output logic                  out_valid,   // a word is available
   input  wire logic             out_ready,   // consumer takes the word
   output logic [WIDTH-1:0]      out_data,    // head word
   output logic                  almost_full  // one slot or none left
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
   localparam logic [AW:0] AF_CNT   = (AW + 1)'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             do_push;
   logic             do_pop;

   // depth must be a power of two so the pointers wrap by themselves
   assign in_ready    = (count != FULL_CNT);
   assign out_valid   = (count != '0);
   assign out_data    = mem[rd_ptr];
   assign almost_full = (count >= AF_CNT);
   assign do_push     = in_valid && in_ready;
   assign do_pop      = out_valid && out_ready;

   // storage has no reset, only the pointers and fill level do
   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (do_push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (do_push && !do_pop) begin
            count <= count + 1'b1;
         end else if (do_pop && !do_push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

//--- dv/fcrc_flash_model.sv
// behavioural flash array answering the crc unit's byte reads
`default_nettype none
module fcrc_flash_model (
   input  wire logic        clk,      // system clock
   input  wire logic        rst_n,    // async reset, active low
   input  wire logic        rd_req,   // read request pulse
   input  wire logic [12:0] addr,     // byte address
   input  wire logic [3:0]  lat,      // cycles from request to data, 1..15
   output logic             rd_valid, // data valid pulse
   output logic [7:0]       rd_data   // read data
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [3:0]  wait_cnt;
   logic [12:0] held_addr;

   // array contents are a fixed function of the address
   function automatic logic [7:0] fdata(input logic [12:0] a);
      return a[7:0] ^ {3'h0, a[12:8]} ^ 8'h5a;
   endfunction

   // one read at a time; the data lines toggle while nothing is driven,
   // so a design that samples them late cannot see a stale byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_cnt  <= 4'h0;
         held_addr <= 13'h0000;
         rd_valid  <= 1'b0;
         rd_data   <= 8'h00;
      end else begin
         rd_valid <= 1'b0;
         rd_data  <= ~rd_data;
         if (rd_req) begin
            wait_cnt  <= lat;
            held_addr <= addr;
         end else if (wait_cnt == 4'h1) begin
            wait_cnt <= 4'h0;
            rd_valid <= 1'b1;
            rd_data  <= fdata(held_addr);
         end else if (wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

//--- dv/fcrc_unit_bench.sv
// self-checking bench of the crc unit with a flash model behind it
`include "fcrc_cfg.svh"
`default_nettype none
module fcrc_unit_bench;
   timeunit 1ns;
   timeprecision 1ns;

   logic        ref_clk;
   logic        rst_n;
   logic [7:0]  sfr_addr;
   logic        sfr_wr;
   logic        sfr_rd;
   logic [7:0]  sfr_wdata;
   logic [7:0]  sfr_rdata;
   logic        cpu_stall;
   logic        flash_rd_req;
   logic [12:0] flash_addr;
   logic        flash_rd_valid;
   logic [7:0]  flash_rd_data;
   logic [3:0]  lat;
   logic        saw_stall;
   logic [12:0] fetch_q[$];
   int          err_count;
   int          check_count;
   int          cyc;

   fcrc_unit uut (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata),
      .cpu_stall(cpu_stall),
      .flash_rd_req(flash_rd_req),
      .flash_addr(flash_addr),
      .flash_rd_valid(flash_rd_valid),
      .flash_rd_data(flash_rd_data)
   );

   fcrc_flash_model flash (
      .clk(ref_clk),
      .rst_n(rst_n),
      .rd_req(flash_rd_req),
      .addr(flash_addr),
      .lat(lat),
      .rd_valid(flash_rd_valid),
      .rd_data(flash_rd_data)
   );

   // ==================================================================
   // clock, monitor and hang guard
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // record every flash fetch and any stall; the ceiling is ~5x the run
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (flash_rd_req) fetch_q.push_back(flash_addr);
      if (cpu_stall) saw_stall <= 1'b1;
      if (cyc == 40000) begin
         err_count++;
         close_out();
      end
   end

   // ==================================================================
   // reference models and helpers
   function automatic logic [15:0] nxt(input logic [15:0] c,
                                       input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {b, 8'h00};
      for (int i = 0; i < 8; i++) r = (r << 1) ^ (r[15] ? `FCRC_POLY : 16'h0);
      return r;
   endfunction

   function automatic logic [7:0] fdata(input logic [12:0] a);
      return a[7:0] ^ {3'h0, a[12:8]} ^ 8'h5a;
   endfunction

   task automatic close_out();
      if (err_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // accesses wait out a stall seen at the negedge; a stall rising at the next posedge still lets one access through
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      while (cpu_stall) @(negedge ref_clk);
      @(posedge ref_clk);
      sfr_wr    <= 1'b1;
      sfr_addr  <= a;
      sfr_wdata <= d;
      @(posedge ref_clk);
      sfr_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      while (cpu_stall) @(negedge ref_clk);
      @(posedge ref_clk);
      sfr_rd   <= 1'b1;
      sfr_addr <= a;
      @(posedge ref_clk);
      sfr_rd <= 1'b0;
      #1 d = sfr_rdata;
   endtask

   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk({8'h00, d}, {8'h00, e});
   endtask

   // ctl keeps the init select bit so reading does not disturb it
   task automatic res_chk(input logic [7:0] ctl, input logic [15:0] e);
      logic [7:0] lo;
      logic [7:0] hi;
      wr(8'h84, ctl);
      rd(8'h86, lo);
      wr(8'h84, ctl | 8'h01);
      rd(8'h86, hi);
      chk({hi, lo}, e);
   endtask

   // ==================================================================
   // scenarios
   task automatic t_reset();
      rc(8'h9e, 8'h40);
      rc(8'h84, 8'h00);
      rc(8'h9a, 8'h00);
      rc(8'h9c, 8'h00);
      res_chk(8'h00, 16'h0000);
   endtask

   task automatic t_flip();
      logic [7:0] v;
      logic [7:0] m;
      for (int k = 1; k < 5; k++) begin
         v = 8'(8'h13 * k);
         for (int j = 0; j < 8; j++) m[j] = v[7 - j];
         wr(8'h9c, v);
         rc(8'h9c, m);
      end
   endtask

   // long runs overfill the fifo, so the stall must show and clear
   task automatic t_sw(input logic ones, input int n);
      logic [15:0] e;
      logic [7:0]  b;
      e = ones ? `FCRC_INIT_ONES : `FCRC_INIT_ZEROS;
      saw_stall = 1'b0;
      wr(8'h84, {5'h01, ones, 2'h0});
      for (int k = 0; k < n; k++) begin
         b = 8'(k * 37 + 11);
         wr(8'h85, b);
         e = nxt(e, b);
      end
      repeat (n * 10 + 10) @(posedge ref_clk);
      res_chk({5'h00, ones, 2'h0}, e);
      rc(8'h84, {5'h00, ones, 2'h1});
      if (n > 20) chk({15'h0, saw_stall}, 16'h1);
   endtask

   task automatic t_dport();
      wr(8'h84, 8'h00);
      wr(8'h86, 8'h12);
      wr(8'h84, 8'h01);
      wr(8'h86, 8'hc3);
      res_chk(8'h00, 16'hc312);
      wr(8'h85, 8'h5a);
      repeat (12) @(posedge ref_clk);
      res_chk(8'h00, nxt(16'hc312, 8'h5a));
   endtask

   task automatic t_areg();
      wr(8'h9e, 8'h7f);
      rc(8'h9e, 8'h5f);
      wr(8'h9e, 8'h00);
      rc(8'h9e, 8'h40);
   endtask

   task automatic t_pass(input logic [4:0] st, input logic [7:0] cnt,
                         input logic [3:0] l);
      logic [15:0] e;
      logic [12:0] base;
      int          w;
      lat  = l;
      base = {st, 8'h00};
      e    = `FCRC_INIT_ONES;
      for (int k = 0; k < cnt * 256; k++) e = nxt(e, fdata(base + 13'(k)));
      wr(8'h9a, cnt);
      wr(8'h9e, {3'h4, st});
      rc(8'h9e, {3'h6, st});
      fetch_q = {};
      wr(8'h84, 8'h0c);
      w = 0;
      while (cpu_stall !== 1'b1 && w < 4) begin
         @(negedge ref_clk);
         w++;
      end
      chk({15'h0, cpu_stall}, 16'h1);
      w = 0;
      while (cpu_stall !== 1'b0 && w < 20000) begin
         @(negedge ref_clk);
         w++;
      end
      // a pass that never ends runs the limit out and counts here
      chk({15'h0, cpu_stall}, 16'h0);
      chk(16'(fetch_q.size()), {cnt, 8'h00});
      foreach (fetch_q[k]) begin
         chk({3'h0, fetch_q[k]}, {3'h0, base + 13'(k)});
      end
      rc(8'h9e, {3'h6, st});
      wr(8'h9e, 8'h00);
      res_chk(8'h04, e);
   endtask

   // ==================================================================
   // main sequence
   initial begin
      rst_n     = 1'b0;
      sfr_addr  = 8'h00;
      sfr_wr    = 1'b0;
      sfr_rd    = 1'b0;
      sfr_wdata = 8'h00;
      lat       = 4'h1;
      saw_stall = 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_reset();
      t_flip();
      t_sw(1'b0, 3);
      t_sw(1'b1, 24);
      t_dport();
      t_areg();
      t_pass(5'h1e, 8'h02, 4'h1);
      t_pass(5'h1f, 8'h01, 4'h5);
      t_pass(5'h00, 8'h00, 4'h1);
      close_out();
   end
endmodule
`default_nettype wire
